// *** verilog/vcd_output_sync.sv ***
`timescale 1ns/1ps

// Overview of operation
// - Readback bit shows calibration running
// - Nonvolatile load with calibrate set starts calibration
// - Calibrate resets zero, rising edge only
// - Calibration timed by VCXO clock edges
// - Dividers held until calibrated and locked
// - Six channels; first two may use VCXO
// - Ten-bit dividers, ratio one to 1024
// - Divider output has half-period duty
// - Per-channel power-down; all down means sleep
// - Tristate stops driver, divider keeps running
// - Low four control bits select driver mode
// - Polarity control swaps levels, default normal
// - Ignore-sync channel skips pin and register syncs, not the first auto sync
// - Sync from register bit or pin
// - Auto sync on first lock after reset or deep sleep
// - Later lock changes do not resync
// - Calibrate bit never clears itself
// - Writes take effect on transfer strobe
module vcd_output_sync #(
  parameter int NUM_CH      = 6,
  parameter int DIV_W       = 10,
  parameter int CAL_CYCLES  = vcd_pkg::CAL_VCXO_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              vcxo_clk,
  input  wire logic              vco_div_clk,
  input  wire logic              output_pll_locked,
  input  wire logic              nvm_load_done,
  input  wire logic              nvm_vco_cal,
  input  wire logic              sync_n,
  output logic [NUM_CH-1:0]      ch_out,
  output logic [NUM_CH-1:0]      ch_drive_en,
  output logic [NUM_CH*4-1:0]    ch_mode,
  output logic [NUM_CH-1:0]      ch_low_power,
  output logic                   deep_sleep,
  output logic                   cal_busy
);

  // Bus slave state
  logic                 aw_got;
  logic                 w_got;
  logic [9:0]           aw_idx;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 wr_en;
  logic [31:0]          wr_mask;
  logic [31:0]          wr_val;
  logic                 wr_hit;
  logic [31:0]          rd_val;
  logic                 rd_hit;
  logic [9:0]           ar_idx;

  // Configuration, shadow and active copies
  logic                 vco_cal_sh;
  logic                 vco_cal;
  logic                 vco_cal_q;
  logic                 sync_bit_sh;
  logic                 sync_bit;
  logic                 transfer;

  // Calibration and sync state
  vcd_pkg::vcd_cal_e    cal_state;
  logic [31:0]          cal_cnt;
  logic                 vcxo_q;
  logic                 vcxo_rise;
  logic                 cal_start;
  logic                 cal_done_once;
  logic                 auto_sync_done;
  logic                 auto_sync;
  logic                 sync_req;
  logic                 vco_q;
  logic                 vco_edge;
  logic                 vcxo_edge;
  logic [NUM_CH-1:0]    ch_pd;

  vcd_pkg::vcd_chan_s   ch_ctrl [NUM_CH];
  vcd_pkg::vcd_phase_s  ch_phase [NUM_CH];
  logic [DIV_W-1:0]     ch_div [NUM_CH];

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en         = aw_got && w_got && !s_axi_bvalid;
  assign wr_mask       = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_val        = w_data & wr_mask;
  assign ar_idx        = s_axi_araddr[11:2];

  // Write address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      aw_idx <= 10'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got <= 1'b1;
      aw_idx <= s_axi_awaddr[11:2];
    end
    else if (wr_en)
      aw_got <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got  <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got  <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_en)
      w_got <= 1'b0;
  end

  always_comb
  begin
    wr_hit = (aw_idx == vcd_pkg::VCO_CONTROL_IDX) || (aw_idx == vcd_pkg::SYNC_CONTROL_IDX)
          || (aw_idx == vcd_pkg::REG_TRANSFER_IDX);
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (aw_idx == vcd_pkg::CH_CTRL_IDX + 10'(i) || aw_idx == vcd_pkg::CH_DIV_IDX + 10'(i)
          || aw_idx == vcd_pkg::CH_PHASE_IDX + 10'(i))
        wr_hit = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= vcd_pkg::RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? vcd_pkg::RESP_OKAY : vcd_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Transfer strobe, self-clearing
  assign transfer = wr_en && aw_idx == vcd_pkg::REG_TRANSFER_IDX && wr_val[vcd_pkg::TRANSFER_BIT];

  // Global shadow and active registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vco_cal_sh  <= 1'b0;
      vco_cal     <= 1'b0;
      sync_bit_sh <= 1'b0;
      sync_bit    <= 1'b0;
    end
    else if (nvm_load_done)
    begin
      vco_cal_sh <= nvm_vco_cal;
      vco_cal    <= nvm_vco_cal;
    end
    else
    begin
      if (wr_en && aw_idx == vcd_pkg::VCO_CONTROL_IDX && w_strb[0])
        vco_cal_sh <= w_data[vcd_pkg::VCO_CAL_BIT];
      if (wr_en && aw_idx == vcd_pkg::SYNC_CONTROL_IDX && w_strb[0])
        sync_bit_sh <= w_data[vcd_pkg::SYNC_DIV_BIT];
      if (transfer)
      begin
        vco_cal  <= vco_cal_sh;
        sync_bit <= sync_bit_sh;
      end
    end
  end

  // Calibration trigger on rising edge of active bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      vco_cal_q <= 1'b0;
    else
      vco_cal_q <= vco_cal;
  end

  assign cal_start = vco_cal && !vco_cal_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vcxo_q <= 1'b0;
      vco_q  <= 1'b0;
    end
    else
    begin
      vcxo_q <= vcxo_clk;
      vco_q  <= vco_div_clk;
    end
  end

  assign vcxo_rise = vcxo_clk && !vcxo_q;
  assign vcxo_edge = vcxo_clk ^ vcxo_q;
  assign vco_edge  = vco_div_clk ^ vco_q;

  // Calibration sequencer timed by VCXO clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cal_state     <= vcd_pkg::CAL_IDLE;
      cal_cnt       <= 32'h00000000;
      cal_done_once <= 1'b0;
    end
    else if (cal_start)
    begin
      cal_state <= vcd_pkg::CAL_RUN;
      cal_cnt   <= 32'h00000000;
    end
    else
    begin
      unique case (cal_state)
        vcd_pkg::CAL_IDLE:
          cal_cnt <= 32'h00000000;
        vcd_pkg::CAL_RUN:
          if (vcxo_rise)
          begin
            if (cal_cnt == 32'(CAL_CYCLES - 1))
            begin
              cal_state     <= vcd_pkg::CAL_IDLE;
              cal_done_once <= 1'b1;
            end
            else
              cal_cnt <= cal_cnt + 32'h00000001;
          end
      endcase
    end
  end

  assign cal_busy = (cal_state == vcd_pkg::CAL_RUN);

  // Automatic sync on first lock, rearmed by reset or deep sleep
  assign auto_sync = output_pll_locked && cal_done_once && !auto_sync_done && !deep_sleep;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      auto_sync_done <= 1'b0;
    else if (deep_sleep)
      auto_sync_done <= 1'b0;
    else if (auto_sync)
      auto_sync_done <= 1'b1;
  end

  assign sync_req   = sync_bit || !sync_n || auto_sync;
  assign deep_sleep = &ch_pd;

  // Per-channel registers and dividers
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : gen_ch
      vcd_pkg::vcd_chan_s  ctrl_sh;
      vcd_pkg::vcd_phase_s phase_sh;
      logic [DIV_W-1:0]    div_sh;
      logic [DIV_W-1:0]    cnt;
      logic                div_q;
      logic                src_edge;
      logic                hold;

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          ctrl_sh     <= vcd_pkg::CH_CTRL_RST;
          div_sh      <= vcd_pkg::CH_DIV_RST;
          phase_sh    <= vcd_pkg::CH_PHASE_RST;
          ch_ctrl[g]  <= vcd_pkg::CH_CTRL_RST;
          ch_div[g]   <= vcd_pkg::CH_DIV_RST;
          ch_phase[g] <= vcd_pkg::CH_PHASE_RST;
        end
        else
        begin
          if (wr_en && aw_idx == vcd_pkg::CH_CTRL_IDX + 10'(g) && w_strb[0])
            ctrl_sh <= w_data[7:0];
          if (wr_en && aw_idx == vcd_pkg::CH_DIV_IDX + 10'(g))
            div_sh <= (div_sh & ~wr_mask[DIV_W-1:0]) | wr_val[DIV_W-1:0];
          if (wr_en && aw_idx == vcd_pkg::CH_PHASE_IDX + 10'(g) && w_strb[0])
            phase_sh <= w_data[7:0];
          if (transfer)
          begin
            ch_ctrl[g]  <= ctrl_sh;
            ch_div[g]   <= div_sh;
            ch_phase[g] <= phase_sh;
          end
        end
      end

      // First two channels may run from the VCXO clock
      if (g < 2)
      begin : gen_src
        assign src_edge = ch_phase[g].vcxo_src ? vcxo_edge : vco_edge;
      end
      else
      begin : gen_vco
        assign src_edge = vco_edge;
      end

      assign hold    = !auto_sync_done || (sync_req && !ch_ctrl[g].ign);
      assign ch_pd[g] = ch_ctrl[g].pd;

      // Toggle every (setting+1) source edges: half-period duty for any ratio
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cnt   <= '0;
          div_q <= 1'b0;
        end
        else if (hold || ch_ctrl[g].pd)
        begin
          cnt   <= DIV_W'(ch_phase[g].phase);
          div_q <= 1'b0;
        end
        else if (src_edge)
        begin
          if (cnt >= ch_div[g])
          begin
            cnt   <= '0;
            div_q <= !div_q;
          end
          else
            cnt <= cnt + DIV_W'(1);
        end
      end

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          ch_out[g]      <= 1'b0;
          ch_drive_en[g] <= 1'b0;
        end
        else
        begin
          ch_drive_en[g] <= !ch_ctrl[g].pd && !deep_sleep && ch_ctrl[g].mode != vcd_pkg::MODE_TRISTATE;
          ch_out[g]      <= (div_q ^ ch_ctrl[g].inv) && !ch_ctrl[g].pd && auto_sync_done;
        end
      end

      assign ch_mode[g*4 +: 4] = ch_ctrl[g].mode;
      assign ch_low_power[g]   = ch_ctrl[g].lowpwr;
    end
  endgenerate

  // Read decode
  always_comb
  begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    unique case (ar_idx)
      vcd_pkg::VCO_CONTROL_IDX:
        rd_val[vcd_pkg::VCO_CAL_BIT] = vco_cal_sh;
      vcd_pkg::CAL_READBACK_IDX:
      begin
        rd_val[vcd_pkg::CAL_BUSY_BIT]       = cal_busy;
        rd_val[vcd_pkg::PLL_LOCKED_BIT]     = output_pll_locked;
        rd_val[vcd_pkg::AUTO_SYNC_DONE_BIT] = auto_sync_done;
      end
      vcd_pkg::SYNC_CONTROL_IDX:
        rd_val[vcd_pkg::SYNC_DIV_BIT] = sync_bit_sh;
      vcd_pkg::REG_TRANSFER_IDX:
        rd_val = 32'h00000000;
      default:
      begin
        rd_hit = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
        begin
          if (ar_idx == vcd_pkg::CH_CTRL_IDX + 10'(i))
          begin
            rd_val = {24'h000000, ch_ctrl[i]};
            rd_hit = 1'b1;
          end
          if (ar_idx == vcd_pkg::CH_DIV_IDX + 10'(i))
          begin
            rd_val = {{(32-DIV_W){1'b0}}, ch_div[i]};
            rd_hit = 1'b1;
          end
          if (ar_idx == vcd_pkg::CH_PHASE_IDX + 10'(i))
          begin
            rd_val = {24'h000000, ch_phase[i]};
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= vcd_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? vcd_pkg::RESP_OKAY : vcd_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// *** include/vcd_pkg.sv ***
package vcd_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] VCO_CONTROL_IDX     = 10'h0F3;
  localparam logic [9:0] CAL_READBACK_IDX    = 10'h22D;
  localparam logic [9:0] SYNC_CONTROL_IDX    = 10'h232;
  localparam logic [9:0] REG_TRANSFER_IDX    = 10'h234;
  localparam logic [9:0] CH_CTRL_IDX         = 10'h300;
  localparam logic [9:0] CH_DIV_IDX          = 10'h310;
  localparam logic [9:0] CH_PHASE_IDX        = 10'h320;

  // Bit positions
  localparam int         VCO_CAL_BIT         = 1;
  localparam int         CAL_BUSY_BIT        = 0;
  localparam int         PLL_LOCKED_BIT      = 1;
  localparam int         AUTO_SYNC_DONE_BIT  = 2;
  localparam int         SYNC_DIV_BIT        = 0;
  localparam int         TRANSFER_BIT        = 0;
  localparam int         PHASE_SRC_BIT       = 7;

  // Reset values and tristate mode code
  localparam logic [7:0] CH_CTRL_RST         = 8'h00;
  localparam logic [9:0] CH_DIV_RST          = 10'h000;
  localparam logic [7:0] CH_PHASE_RST        = 8'h00;
  localparam logic [3:0] MODE_TRISTATE       = 4'hF;

  // Timing
  localparam int         CAL_VCXO_CYCLES     = 1024;

  // AXI responses
  localparam logic [1:0] RESP_OKAY           = 2'h0;
  localparam logic [1:0] RESP_SLVERR         = 2'h2;

  typedef struct packed {
    logic       lowpwr;
    logic       pd;
    logic       ign;
    logic       inv;
    logic [3:0] mode;
  } vcd_chan_s;

  typedef struct packed {
    logic       vcxo_src;
    logic [1:0] unused;
    logic [4:0] phase;
  } vcd_phase_s;

  typedef enum logic {
    CAL_IDLE,
    CAL_RUN
  } vcd_cal_e;

endpackage

// *** bench/vcd_clock_source.sv ***
`timescale 1ns/1ps

module vcd_clock_source (
  input  wire logic aclk,
  input  wire logic lock_req,
  output logic      vcxo_clk,
  output logic      vco_div_clk,
  output logic      output_pll_locked
);
  logic [1:0] c3 = 2'h0;
  logic [1:0] c4 = 2'h0;
  logic [2:0] lk = 3'h0;
  logic       vx = 1'h0;
  logic       vd = 1'h0;

  // Free-running clocks, lock lags the request
  always_ff @(posedge aclk)
  begin
    c3 <= (c3 == 2'h2) ? 2'h0 : c3 + 2'h1;
    c4 <= c4 + 2'h1;
    lk <= {lk[1:0], lock_req};
    if (c3 == 2'h2)
      vx <= ~vx;
    if (c4 == 2'h3)
      vd <= ~vd;
  end

  assign vcxo_clk          = vx;
  assign vco_div_clk       = vd;
  assign output_pll_locked = lk[2];
endmodule

// *** bench/vcd_output_sync_checker.sv ***
`timescale 1ns/1ps

module vcd_output_sync_checker #(
  parameter int NUM_CH     = 6,
  parameter int CAL_CYCLES = 1024
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                vcxo_clk,
  input wire logic                output_pll_locked,
  input wire logic [NUM_CH-1:0]   ch_out,
  input wire logic [NUM_CH-1:0]   ch_drive_en,
  input wire logic [NUM_CH*4-1:0] ch_mode,
  input wire logic                deep_sleep,
  input wire logic                cal_busy
);
  logic seen_done;
  logic seen_lock;
  logic vcxo_q;
  int   vcnt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seen_done <= 1'h0;
      seen_lock <= 1'h0;
    end
    else
    begin
      if ($fell(cal_busy))
        seen_done <= 1'h1;
      if (output_pll_locked)
        seen_lock <= 1'h1;
    end
  end

  // VCXO rising edges seen while busy
  always_ff @(posedge aclk)
  begin
    vcxo_q <= vcxo_clk;
    if (!cal_busy)
      vcnt <= 0;
    else if (vcxo_clk && !vcxo_q)
      vcnt <= vcnt + 1;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  a_bresp_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
    else $error("read data dropped early");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_out_gated: assert property (ch_out != '0 |-> seen_done && seen_lock)
    else $error("outputs before calibration and lock");
  a_busy_span: assert property ($fell(cal_busy) |-> vcnt >= CAL_CYCLES)
    else $error("calibration ended early");
  a_sleep_off: assert property (deep_sleep |=> ch_drive_en == '0)
    else $error("driver on in deep sleep");
  a_tristate_off: assert property (ch_mode[7:4] == 4'hF |=> !ch_drive_en[1])
    else $error("tristate driver still on");
endmodule

bind vcd_output_sync vcd_output_sync_checker #(.NUM_CH(NUM_CH), .CAL_CYCLES(CAL_CYCLES)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .vcxo_clk(vcxo_clk), .output_pll_locked(output_pll_locked), .ch_out(ch_out),
  .ch_drive_en(ch_drive_en), .ch_mode(ch_mode), .deep_sleep(deep_sleep), .cal_busy(cal_busy));

// *** bench/vcd_output_sync_bench.sv ***
`timescale 1ns/1ps

module vcd_output_sync_bench;
  localparam logic [9:0] VC = vcd_pkg::VCO_CONTROL_IDX;
  localparam logic [9:0] RB = vcd_pkg::CAL_READBACK_IDX;
  localparam logic [9:0] CT = vcd_pkg::CH_CTRL_IDX;
  localparam logic [9:0] DV = vcd_pkg::CH_DIV_IDX;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lock_req;
  logic        awready, wready, bvalid, arready, rvalid, nvm_done, nvm_cal, sync_n;
  logic        vcxo, vcod, locked, deep_sleep, cal_busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, dv;
  logic [1:0]  bresp, rresp;
  logic [5:0]  ch_out, ch_en;
  logic [23:0] ch_mode;
  logic [33:0] rq[$];
  int          error_cnt, compares, seed, hi, lo;

  vcd_output_sync #(.CAL_CYCLES(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .vcxo_clk(vcxo), .vco_div_clk(vcod), .output_pll_locked(locked), .nvm_load_done(nvm_done),
    .nvm_vco_cal(nvm_cal), .sync_n(sync_n), .ch_out(ch_out), .ch_drive_en(ch_en),
    .ch_mode(ch_mode), .ch_low_power(), .deep_sleep(deep_sleep), .cal_busy(cal_busy));

  vcd_clock_source i_src (
    .aclk(aclk), .lock_req(lock_req), .vcxo_clk(vcxo), .vco_div_clk(vcod),
    .output_pll_locked(locked));

  task chk(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er = vcd_pkg::RESP_OKAY);
    logic a, w;
    a = 1'h0;
    w = 1'h0;
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(a && w))
    begin
      @(posedge aclk);
      if (!a && awready)
      begin
        a = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w && wready)
      begin
        w = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h1;
    @(posedge aclk);
    chk(bresp, er);
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  task rd(input logic [9:0] idx, input logic [33:0] e);
    rq.push_back(e);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h1;
    @(posedge aclk);
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  // Read results against the oldest note
  always @(posedge aclk)
    if (rvalid && rready)
      chk({rresp, rdata}, (rq.size() != 0) ? rq.pop_front() : {34{1'bx}});

  task xfer();
    wr(vcd_pkg::REG_TRANSFER_IDX, 32'h1);
  endtask

  task wait_busy(input logic v);
    while (cal_busy !== v)
      @(posedge aclk);
  endtask

  task duty();
    hi = 0;
    lo = 0;
    while (ch_out[0] !== 1'h0) @(posedge aclk);
    while (ch_out[0] !== 1'h1) @(posedge aclk);
    while (ch_out[0] === 1'h1) begin hi++; @(posedge aclk); end
    while (ch_out[0] === 1'h0) begin lo++; @(posedge aclk); end
  endtask

  task hold();
    int   t;
    logic z, p;
    repeat (4) @(posedge aclk);
    z = 1'h0;
    t = 0;
    p = ch_out[3];
    repeat (30)
    begin
      @(posedge aclk);
      z = z | ch_out[0];
      t += (ch_out[3] != p);
      p = ch_out[3];
    end
    chk(z, 1'h0);
    chk(t != 0, 1'h1);
  endtask

  task align();
    repeat (40) @(posedge aclk);
    repeat (24)
    begin
      @(posedge aclk);
      chk(ch_out[5:4], {ch_out[0], ~ch_out[0]});
    end
  endtask

  task wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, nvm_done, nvm_cal, lock_req} = 9'h0;
    {awaddr, araddr, wdata} = 56'h0;
    sync_n = 1'h1;
    error_cnt = 0;
    compares = 0;
    seed = 85918;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(VC, 34'h0);
    rd(RB, 34'h0);
    rd(10'h3FF, {vcd_pkg::RESP_SLVERR, 32'h0});
    wr(10'h3FF, 32'h1, vcd_pkg::RESP_SLVERR);
    wr(DV, 32'h2);
    wr(DV + 10'h4, 32'h2);
    wr(DV + 10'h5, 32'h2);
    wr(CT + 10'h4, 32'h10);
    wr(CT + 10'h1, 32'h0F);
    wr(CT + 10'h3, 32'h20);
    dv = $random(seed) & 32'h3FF;
    wr(DV + 10'h2, dv);
    rd(CT + 10'h1, 34'h0);
    xfer();
    rd(CT + 10'h1, 34'h0F);
    rd(DV + 10'h2, {2'h0, dv});
    chk(ch_mode[7:4], 4'hF);
    chk(ch_en, 6'h3D);
    nvm_cal <= 1'h1;
    nvm_done <= 1'h1;
    @(posedge aclk);
    nvm_done <= 1'h0;
    wait_busy(1'h1);
    rd(RB, 34'h1);
    rd(VC, 34'h2);
    wait_busy(1'h0);
    rd(RB, 34'h0);
    repeat (20) @(posedge aclk);
    chk(ch_out, 6'h0);
    lock_req <= 1'h1;
    duty();
    chk(hi, 12);
    chk(lo, 12);
    rd(RB, 34'h6);
    sync_n <= 1'h0;
    hold();
    sync_n <= 1'h1;
    align();
    wr(vcd_pkg::SYNC_CONTROL_IDX, 32'h1);
    xfer();
    hold();
    wr(vcd_pkg::SYNC_CONTROL_IDX, 32'h0);
    xfer();
    align();
    wr(VC, 32'h2);
    xfer();
    repeat (4) @(posedge aclk);
    chk(cal_busy, 1'h0);
    rd(VC, 34'h2);
    wr(VC, 32'h0);
    xfer();
    wr(VC, 32'h2);
    xfer();
    chk(cal_busy, 1'h1);
    wait_busy(1'h0);
    for (int i = 0; i < 6; i++)
      wr(CT + 10'(i), 32'h40);
    xfer();
    repeat (2) @(posedge aclk);
    chk({deep_sleep, ch_en, ch_out}, 13'h1000);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(VC, 34'h0);
    wrap_up();
  end
endmodule
